// File: include/eic_defs.vh
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH
// register indexes (word aligned on the bus: index*4)
`define EIC_IDX_PFN 16'hffeb
`define EIC_IDX_EDG 16'hfff2
`define EIC_IDX_EN1 16'hfff3
`define EIC_IDX_EN2 16'hfff4
`define EIC_IDX_EN3 16'hfff5
`define EIC_IDX_RQ1 16'hfff6
`define EIC_IDX_RQ2 16'hfff7
`define EIC_IDX_RQ3 16'hfff8
`define EIC_IDX_CTL 16'hfff9
// reset values
`define EIC_RST_PFN 8'h0c
`define EIC_RST_EDG 8'hec
`define EIC_RST_EN1 8'hc0
`define EIC_RST_EN2 8'h00
`define EIC_RST_EN3 8'h3c
`define EIC_RST_RQ1 8'hc0
`define EIC_RST_RQ2 8'h00
`define EIC_RST_RQ3 8'h3c
// fixed one bits of read-only fields
`define EIC_FIX_PFN 8'h0c
`define EIC_FIX_EDG 8'hec
`define EIC_FIX_EN1 8'hc0
`define EIC_FIX_EN3 8'h3c
// pin function fields
`define EIC_PFN_NOISE 7
`define EIC_PFN_EVENT 6
// vectors
`define EIC_VEC_RESET 16'h0000
`define EIC_VEC_LINE0 16'h0008
`define EIC_VEC_LINE1 16'h000a
`define EIC_VEC_LINE4 16'h0010
`define EIC_VEC_LINE5 16'h0012
`define EIC_VEC_KEY 16'h0014
`define EIC_VEC_TIMA 16'h0016
`define EIC_VEC_DT 16'h0020
`define EIC_VEC_SER1 16'h0026
`define EIC_VEC_SER2 16'h0028
`define EIC_VEC_AD 16'h002a
// timing
`define EIC_FILT_STATES 256
`define EIC_DT_DELAY 1024
`endif

// File: src/eic_ctrl.v
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "eic_defs.vh"
// How it works
// - reset sequence outranks every interrupt
// - low reset pin returns all state to its reset values
// - reset sets the global mask bit
// - vector fetch starts at reset release
// - reset vector word loads program counter
// - interrupts start only at instruction end
// - highest fixed priority pending served first
// - mask blocks acceptance, flags still set
// - lines 0,1,4 have selectable edge
// - line 5 senses falling edge only
// - external vectors 0x08,0x0a,0x10,0x12
// - internal vectors 0x14 through 0x2a
// - sleep arms delayed direct transfer request
// - request flags clear only by zero
// - select bits route pins to lines
// - bit 7 enables line 0 filter
// - filter samples every 256 states
// - bit 6 selects event count input
// - edge bit zero falling, one rising
// - enable bit passes flag to core
module eic_ctrl #(
  parameter FILT_STATES = `EIC_FILT_STATES,
  parameter DT_DELAY = `EIC_DT_DELAY
) (
  input wire clk,
  input wire rst_n,
  input wire [15:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [5:0] port1_pin,
  input wire [4:0] timer_ovf,
  input wire key_scan_evt,
  input wire serial1_evt,
  input wire serial2_evt,
  input wire ad_end_evt,
  input wire sleep_exec,
  input wire insn_done,
  input wire [15:0] mem_rdata,
  input wire mem_rvalid,
  input wire mask_set_req,
  input wire mask_clr_req,
  output reg mem_rd,
  output reg [15:0] mem_addr,
  output reg [15:0] prog_counter,
  output reg pc_load,
  output reg cpu_run,
  output reg int_take,
  output reg [15:0] int_vector,
  output wire glob_mask,
  output wire event_pin_sel,
  output wire event_in
);
  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  localparam ST_RESET = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_RUN = 2'd3;
  reg [1:0] state_r;
  reg mask_r;
  reg [7:0] pfn_r;
  reg [7:0] edg_r;
  reg [7:0] en1_r;
  reg [7:0] en2_r;
  reg [7:0] en3_r;
  reg [7:0] rq1_r;
  reg [7:0] rq2_r;
  reg [7:0] rq3_r;
  reg [17:0] sync_r;
  reg [5:0] prev_r;
  reg [7:0] fcnt_r;
  reg fsamp_r;
  reg f0_r;
  reg dt_arm_r;
  reg [15:0] dt_cnt_r;
  reg rd_pend_r;
  wire [15:0] word_addr;
  wire wr_go;
  wire [7:0] wbyte;
  wire [5:0] pin_s;
  wire line0_in;
  wire [7:0] pend;
  wire [7:0] pend2;
  wire [7:0] pend3;
  wire [13:0] pend_all;
  wire dt_fire;
  wire [7:0] set1;
  wire [7:0] set2;
  wire [7:0] set3;

  // byte lane 0 carries the 8-bit register data
  // all indexes sit in the top quarter, so the two bits lost to the shift are ones
  assign word_addr = {2'b11, avs_address[15:2]};
  assign wr_go = avs_write & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  // reads answer one cycle later; writes take effect at once
  assign avs_waitrequest = avs_read & ~rd_pend_r;
  assign glob_mask = mask_r;
  assign event_pin_sel = pfn_r[`EIC_PFN_EVENT];
  assign event_in = pfn_r[`EIC_PFN_EVENT] & pin_s[5];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // edge detect with a polarity: 0 falling, 1 rising
  function edge_hit;
    input prv;
    input cur;
    input rise;
    begin
      edge_hit = rise ? (~prv & cur) : (prv & ~cur);
    end
  endfunction

  // clear-by-zero with set winning over clear
  function [7:0] flag_upd;
    input [7:0] cur;
    input [7:0] wdat;
    input wen;
    input [7:0] setv;
    input [7:0] fixed;
    begin
      flag_upd = ((wen ? (cur & wdat) : cur) | setv) | fixed;
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers (three stages per pin)
  // ----------------------------------------
  // pin order: 0 line0, 1 line1, 2 line4, 3 line5, 4 unused, 5 event pin
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_r <= 18'h3ffff;
    else
      sync_r <= {sync_r[11:0], port1_pin};
  end

  // a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_pin
      assign pin_s[gi] = (sync_r[6 + gi] == sync_r[12 + gi]) ? sync_r[12 + gi] : prev_r[gi];
    end
  endgenerate

  // ----------------------------------------
  // line 0 glitch filter
  // ----------------------------------------
  // two samples 256 states apart must match before line 0 moves
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fcnt_r <= 8'h00;
      fsamp_r <= 1'b1;
      f0_r <= 1'b1;
    end
    else
    begin
      fcnt_r <= (fcnt_r == FILT_STATES - 1) ? 8'h00 : fcnt_r + 8'h01;
      if (fcnt_r == FILT_STATES - 1)
      begin
        fsamp_r <= pin_s[0];
        if (fsamp_r == pin_s[0])
          f0_r <= pin_s[0];
      end
    end
  end

  // filter adds latency; unfiltered input follows the pin directly
  assign line0_in = pfn_r[`EIC_PFN_NOISE] ? f0_r : pin_s[0];

  // ----------------------------------------
  // direct transfer timer
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dt_arm_r <= 1'b0;
      dt_cnt_r <= 16'h0000;
    end
    else if (sleep_exec)
    begin
      dt_arm_r <= 1'b1;
      dt_cnt_r <= 16'h0000;
    end
    else if (dt_arm_r)
    begin
      dt_cnt_r <= dt_cnt_r + 16'h0001;
      if (dt_fire)
        dt_arm_r <= 1'b0;
    end
  end

  assign dt_fire = dt_arm_r & (dt_cnt_r == DT_DELAY[15:0] - 16'h0001);

  // ----------------------------------------
  // event sources into flags
  // ----------------------------------------
  // only pins routed to their line raise a flag
  assign set1 = {2'b00,
    pfn_r[5] & edge_hit(prev_r[3], pin_s[3], 1'b0),
    pfn_r[4] & edge_hit(prev_r[2], pin_s[2], edg_r[4]),
    2'b00,
    pfn_r[1] & edge_hit(prev_r[1], pin_s[1], edg_r[1]),
    pfn_r[0] & edge_hit(prev_r[0], line0_in, edg_r[0])};
  assign set2 = {2'b00, dt_fire, timer_ovf};
  assign set3 = {ad_end_evt, key_scan_evt, 4'h0, serial2_evt, serial1_evt};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= 6'h3f;
    else
      prev_r <= {pin_s[5:1], line0_in};
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pfn_r <= `EIC_RST_PFN;
      edg_r <= `EIC_RST_EDG;
      en1_r <= `EIC_RST_EN1;
      en2_r <= `EIC_RST_EN2;
      en3_r <= `EIC_RST_EN3;
      rq1_r <= `EIC_RST_RQ1;
      rq2_r <= `EIC_RST_RQ2;
      rq3_r <= `EIC_RST_RQ3;
    end
    else
    begin
      if (wr_go && word_addr == `EIC_IDX_PFN)
        pfn_r <= wbyte | `EIC_FIX_PFN;
      if (wr_go && word_addr == `EIC_IDX_EDG)
        edg_r <= wbyte | `EIC_FIX_EDG;
      if (wr_go && word_addr == `EIC_IDX_EN1)
        en1_r <= wbyte | `EIC_FIX_EN1;
      if (wr_go && word_addr == `EIC_IDX_EN2)
        en2_r <= wbyte;
      if (wr_go && word_addr == `EIC_IDX_EN3)
        en3_r <= wbyte | `EIC_FIX_EN3;
      rq1_r <= flag_upd(rq1_r, wbyte, wr_go && word_addr == `EIC_IDX_RQ1, set1,
        `EIC_RST_RQ1);
      rq2_r <= flag_upd(rq2_r, wbyte, wr_go && word_addr == `EIC_IDX_RQ2, set2,
        `EIC_RST_RQ2);
      rq3_r <= flag_upd(rq3_r, wbyte, wr_go && word_addr == `EIC_IDX_RQ3, set3,
        `EIC_RST_RQ3);
    end
  end

  // read data one cycle after the request; unmapped reads zero
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_pend_r <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      rd_pend_r <= avs_read & ~rd_pend_r;
      case (word_addr)
        `EIC_IDX_PFN: avs_readdata <= {24'h000000, pfn_r};
        `EIC_IDX_EDG: avs_readdata <= {24'h000000, edg_r};
        `EIC_IDX_EN1: avs_readdata <= {24'h000000, en1_r};
        `EIC_IDX_EN2: avs_readdata <= {24'h000000, en2_r};
        `EIC_IDX_EN3: avs_readdata <= {24'h000000, en3_r};
        `EIC_IDX_RQ1: avs_readdata <= {24'h000000, rq1_r};
        `EIC_IDX_RQ2: avs_readdata <= {24'h000000, rq2_r};
        `EIC_IDX_RQ3: avs_readdata <= {24'h000000, rq3_r};
        `EIC_IDX_CTL: avs_readdata <= {30'h0, cpu_run, mask_r};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // priority and vector
  // ----------------------------------------
  assign pend = rq1_r & en1_r & 8'h33;
  assign pend2 = rq2_r & en2_r & 8'h3f;
  assign pend3 = rq3_r & en3_r & 8'hc3;
  // index 0 is the highest priority
  assign pend_all = {pend3[7], pend3[1], pend3[0], pend2[5:0], pend3[6], pend[5], pend[4],
    pend[1], pend[0]};

  function [15:0] vec_of;
    input [13:0] p;
    integer k;
    begin
      vec_of = `EIC_VEC_AD;
      for (k = 13; k >= 0; k = k - 1)
        if (p[k])
        begin
          case (k)
            0: vec_of = `EIC_VEC_LINE0;
            1: vec_of = `EIC_VEC_LINE1;
            2: vec_of = `EIC_VEC_LINE4;
            3: vec_of = `EIC_VEC_LINE5;
            4: vec_of = `EIC_VEC_KEY;
            10: vec_of = `EIC_VEC_DT;
            11: vec_of = `EIC_VEC_SER1;
            12: vec_of = `EIC_VEC_SER2;
            13: vec_of = `EIC_VEC_AD;
            default: vec_of = `EIC_VEC_TIMA + {k[14:0] - 15'd5, 1'b0};
          endcase
        end
    end
  endfunction

  // ----------------------------------------
  // reset sequence and acceptance
  // ----------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_RESET;
      mask_r <= 1'b1;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
      prog_counter <= 16'h0000;
      pc_load <= 1'b0;
      cpu_run <= 1'b0;
      int_take <= 1'b0;
      int_vector <= 16'h0000;
    end
    else
    begin
      pc_load <= 1'b0;
      int_take <= 1'b0;
      case (state_r)
        ST_RESET:
        begin
          // no instruction boundary wait after release
          mem_rd <= 1'b1;
          mem_addr <= `EIC_VEC_RESET;
          state_r <= ST_WAIT;
        end
        ST_WAIT:
          if (mem_rvalid)
          begin
            mem_rd <= 1'b0;
            prog_counter <= mem_rdata;
            pc_load <= 1'b1;
            cpu_run <= 1'b1;
            state_r <= ST_RUN;
          end
        ST_RUN:
        begin
          if (mask_clr_req)
            mask_r <= 1'b0;
          if (mask_set_req)
            mask_r <= 1'b1;
          // taking an interrupt masks further ones
          if (insn_done && !mask_r && |pend_all)
          begin
            int_take <= 1'b1;
            int_vector <= vec_of(pend_all);
            mask_r <= 1'b1;
          end
        end
        default:
          state_r <= ST_RESET;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/eic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------
// core model
// ----------
module eic_core_model #(
  parameter logic [15:0] BOOT = 16'h0100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_rd,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata,
  output logic insn_done
);
  logic [1:0] cnt_r;
  logic done_r;
  // one slow boot answer per reset, then an instruction end every 4th state
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_r <= 2'h0;
      done_r <= 1'b0;
      mem_rvalid <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      mem_rvalid <= mem_rd && !done_r && !mem_rvalid && cnt_r == 2'h3;
      done_r <= done_r || mem_rvalid;
    end
  // idle bus shows the inverse so a stale word never passes
  assign mem_rdata = mem_rvalid ? BOOT : ~BOOT;
  assign insn_done = done_r && cnt_r == 2'h0;
endmodule
`default_nettype wire

// File: verif/eic_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ------------
// port checker
// ------------
module eic_ctrl_chk (
  input wire clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_waitrequest,
  input wire insn_done,
  input wire [15:0] mem_rdata,
  input wire mem_rvalid,
  input wire [15:0] mem_addr,
  input wire mem_rd,
  input wire pc_load,
  input wire cpu_run,
  input wire [15:0] prog_counter,
  input wire int_take,
  input wire [15:0] int_vector,
  input wire glob_mask
);
  // one clock domain; nothing is judged while reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // read answers after one wait state
  sequence s_rd;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_boot;
    mem_rd && mem_addr == 16'h0000 && glob_mask && !cpu_run;
  endsequence
  property p_boot;
    $rose(rst_n) |=> s_boot;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot fetch");
  property p_load;
    mem_rd && mem_rvalid |=> pc_load && cpu_run && prog_counter == $past(mem_rdata);
  endproperty
  a_load: assert property (p_load) else $error("bad pc load");
  property p_pulse;
    pc_load |-> cpu_run ##1 !pc_load;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pc load stuck");
  property p_take;
    int_take |-> glob_mask && $past(insn_done) && !$past(glob_mask);
  endproperty
  a_take: assert property (p_take) else $error("bad take");
  property p_run;
    !cpu_run |-> !int_take;
  endproperty
  a_run: assert property (p_run) else $error("take in reset seq");
  property p_vec;
    int_take |-> int_vector inside {16'h0008, 16'h000a, 16'h0010, 16'h0012, 16'h0014,
      16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0026, 16'h0028, 16'h002a};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_once;
    int_take |=> !int_take;
  endproperty
  a_once: assert property (p_once) else $error("double take");
  property p_rd;
    $rose(avs_read) |-> s_rd;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait");
endmodule
bind eic_ctrl eic_ctrl_chk u_eic_ctrl_chk (.clk, .rst_n, .avs_read, .avs_waitrequest,
  .insn_done, .mem_rdata, .mem_rvalid, .mem_addr, .mem_rd, .pc_load, .cpu_run,
  .prog_counter, .int_take, .int_vector, .glob_mask);
`default_nettype wire

// File: verif/eic_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------
// bench top
// ----------
module eic_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [5:0] pin = 6'h3f;
  logic [9:0] ev = 10'h000;
  logic mclr = 1'b0;
  logic mset = 1'b0;
  logic [31:0] rdat;
  logic wreq, mrd, mval, idone, tk, gm, run, pcl, ep, ei;
  logic [15:0] mad, mdat, pc, vec;
  int fails = 0;
  int cmp_count = 0;
  logic [15:0] ra [8] = '{16'hffeb, 16'hfff2, 16'hfff3, 16'hfff4, 16'hfff5, 16'hfff6,
    16'hfff7, 16'hfff8};
  logic [7:0] rv [8] = '{8'h0c, 8'hec, 8'hc0, 8'h00, 8'h3c, 8'hc0, 8'h00, 8'h3c};
  logic [7:0] wv [8] = '{8'h40, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] w1 [8] = '{8'h4c, 8'hff, 8'hff, 8'hff, 8'hff, 8'hc0, 8'h00, 8'h3c};
  // short counts keep the filter and sleep delay quick
  eic_ctrl #(.FILT_STATES(4), .DT_DELAY(8)) u_eic_ctrl (.clk, .rst_n, .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata({24'h0, wd}), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .port1_pin(pin), .timer_ovf(ev[4:0]),
    .key_scan_evt(ev[5]), .serial1_evt(ev[6]), .serial2_evt(ev[7]), .ad_end_evt(ev[8]),
    .sleep_exec(ev[9]), .insn_done(idone), .mem_rdata(mdat), .mem_rvalid(mval),
    .mask_set_req(mset), .mask_clr_req(mclr), .mem_rd(mrd), .mem_addr(mad),
    .prog_counter(pc), .pc_load(pcl), .cpu_run(run), .int_take(tk), .int_vector(vec),
    .glob_mask(gm), .event_pin_sel(ep), .event_in(ei));
  eic_core_model u_eic_core_model (.clk, .rst_n, .mem_rd(mrd), .mem_rvalid(mval),
    .mem_rdata(mdat), .insn_done(idone));
  // clock at 8 ns
  always #4 clk = ~clk;
  task automatic stop_test;
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // every wait is bounded; a hang ends the run as a failure
  task automatic tick(inout int n);
    @(posedge clk);
    if (++n > 60)
    begin
      fails++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    adr <= i << 2;
    wd <= d;
    wr_en <= 1'b1;
    do tick(n); while (wreq !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] i, input logic [7:0] e);
    int n = 0;
    @(posedge clk);
    adr <= i << 2;
    rd_en <= 1'b1;
    do tick(n); while (wreq !== 1'b0);
    chk(rdat, {24'h0, e});
    rd_en <= 1'b0;
  endtask
  // clear the mask, then wait for the core to be vectored
  task automatic take(input logic [15:0] v);
    int n = 0;
    @(posedge clk);
    mclr <= 1'b1;
    @(posedge clk);
    mclr <= 1'b0;
    while (tk !== 1'b1) tick(n);
    chk(vec, v);
  endtask
  task automatic pulse(input logic [9:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 10'h000;
  endtask
  task automatic hold(input logic [5:0] p, input int c);
    pin <= p;
    repeat (c) @(posedge clk);
  endtask
  // main sequence
  initial
  begin
    int n = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
    while (run !== 1'b1) tick(n);
    chk(pc, 16'h0100);
    rc(16'hfff9, 8'h03);
    @(posedge clk);
    mclr <= 1'b1;
    @(posedge clk);
    mclr <= 1'b0;
    rc(16'hfff9, 8'h02);
    @(posedge clk);
    {mclr, mset} <= 2'b11;
    @(posedge clk);
    {mclr, mset} <= 2'b00;
    rc(16'hfff9, 8'h03);
    rc(16'hfff0, 8'h00);
    for (int i = 0; i < 8; i++) wr(ra[i], wv[i]);
    for (int i = 0; i < 8; i++) rc(ra[i], w1[i]);
    chk({ep, ei}, 2'b11);
    for (int i = 0; i < 8; i++) wr(ra[i], 8'h00);
    chk({ep, ei}, 2'b00);
    wr(16'hfff4, 8'h01);
    wr(16'hfff5, 8'h01);
    pulse(10'h041);
    rc(16'hfff7, 8'h01);
    rc(16'hfff8, 8'h3d);
    wr(16'hfff7, 8'hff);
    rc(16'hfff7, 8'h01);
    take(16'h0016);
    wr(16'hfff7, 8'h00);
    take(16'h0026);
    wr(16'hfff8, 8'h00);
    wr(16'hfff5, 8'hc2);
    pulse(10'h1a0);
    take(16'h0014);
    wr(16'hfff8, 8'hbf);
    take(16'h0028);
    wr(16'hfff8, 8'hfd);
    take(16'h002a);
    wr(16'hfff8, 8'h00);
    wr(16'hfff5, 8'h00);
    wr(16'hffeb, 8'h22);
    wr(16'hfff2, 8'h02);
    wr(16'hfff6, 8'h00);
    wr(16'hfff3, 8'h22);
    hold(6'h3d, 12);
    rc(16'hfff6, 8'hc0);
    hold(6'h3f, 12);
    rc(16'hfff6, 8'hc2);
    take(16'h000a);
    wr(16'hfff6, 8'h00);
    hold(6'h37, 12);
    rc(16'hfff6, 8'he0);
    take(16'h0012);
    hold(6'h3f, 1);
    wr(16'hfff3, 8'h00);
    wr(16'hffeb, 8'h81);
    wr(16'hfff6, 8'h00);
    // long enough to pass the synchroniser, too short for two samples
    hold(6'h3e, 3);
    hold(6'h3f, 20);
    rc(16'hfff6, 8'hc0);
    hold(6'h3e, 30);
    rc(16'hfff6, 8'hc1);
    wr(16'hfff4, 8'h20);
    pulse(10'h200);
    rc(16'hfff7, 8'h00);
    take(16'h0020);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc(16'hffeb, 8'h0c);
    rc(16'hfff4, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
